// >>> logic/power_host_ctrl.sv
// host end: drives supply, request, reset and commands toward the module
`timescale 1ns/1ps
module power_host_ctrl #(
    parameter int unsigned POWER_ON_REQUEST_N_LOW = power_seq_pkg::POWER_ON_REQUEST_N_LOW_CYC,
    parameter int unsigned RESET_LOW = power_seq_pkg::RESET_LOW_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    power_link_if.host link,
    input wire logic supply_enable,
    input wire logic wake_request,
    input wire logic hard_reset_request,
    input wire logic cmd_request,
    input wire power_seq_pkg::cmd_e cmd_op_in,
    input wire logic [7:0] cmd_arg_in,
    output logic cmd_done,
    output logic module_ready,
    output logic module_on
);
    import power_seq_pkg::*;

    // ============================================================
    // status inputs come from another block's pins
    logic [1:0] rdy_s_q, vint_s_q, ok_s_q;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdy_s_q <= 2'h0;
            vint_s_q <= 2'h0;
            ok_s_q <= 2'h0;
        end else begin
            rdy_s_q <= {rdy_s_q[0], link.ready};
            vint_s_q <= {vint_s_q[0], link.interface_supply_on};
            ok_s_q <= {ok_s_q[0], link.cmd_ok};
        end
    end

    // ============================================================
    // pulse generators and command issue
    logic [CNT_W-1:0] pon_cnt_q, pon_cnt_d, rst_cnt_q, rst_cnt_d;
    logic sup_q, sup_d, pend_q, pend_d, cv_q, cv_d, done_q, done_d;
    cmd_e op_q, op_d;
    logic [7:0] arg_q, arg_d;
    logic ok_seen_q;

    always_comb begin
        pon_cnt_d = pon_cnt_q;
        rst_cnt_d = rst_cnt_q;
        if (pon_cnt_q != '0) begin
            pon_cnt_d = pon_cnt_q - CNT_W'(1);
        end else if (wake_request) begin
            // margin of a few cycles covers the far synchroniser
            pon_cnt_d = CNT_W'(POWER_ON_REQUEST_N_LOW + 4);
        end
        if (rst_cnt_q != '0) begin
            rst_cnt_d = rst_cnt_q - CNT_W'(1);
        end else if (hard_reset_request) begin
            rst_cnt_d = CNT_W'(RESET_LOW + 4);
        end
        // keep supply until the module has dropped its interface supply
        sup_d = supply_enable || (sup_q && vint_s_q[1]);
        pend_d = pend_q;
        op_d = op_q;
        arg_d = arg_q;
        cv_d = 1'b0;
        done_d = 1'b0;
        if (!pend_q && cmd_request && rdy_s_q[1]) begin
            pend_d = 1'b1;
            cv_d = 1'b1;
            op_d = cmd_op_in;
            arg_d = cmd_arg_in;
        end else if (pend_q && ok_s_q[1] && !ok_seen_q) begin
            pend_d = 1'b0;
            done_d = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pon_cnt_q <= '0;
            rst_cnt_q <= '0;
            sup_q <= 1'b0;
            pend_q <= 1'b0;
            cv_q <= 1'b0;
            done_q <= 1'b0;
            op_q <= CMD_NONE;
            arg_q <= 8'h00;
            ok_seen_q <= 1'b0;
        end else begin
            pon_cnt_q <= pon_cnt_d;
            rst_cnt_q <= rst_cnt_d;
            sup_q <= sup_d;
            pend_q <= pend_d;
            cv_q <= cv_d;
            done_q <= done_d;
            op_q <= op_d;
            arg_q <= arg_d;
            ok_seen_q <= ok_s_q[1];
        end
    end

    assign link.main_supply_ok = sup_q;
    assign link.power_on_request_n = (pon_cnt_q == '0);
    assign link.reset_n = (rst_cnt_q == '0);
    assign link.cmd_valid = cv_q;
    assign link.cmd_op = op_q;
    assign link.cmd_arg = arg_q;
    assign cmd_done = done_q;
    assign module_ready = rdy_s_q[1];
    assign module_on = vint_s_q[1];
endmodule : power_host_ctrl

// >>> logic/power_link_if.sv
// link between the host and the power-state sequencer
`timescale 1ns/1ps
interface power_link_if;
    import power_seq_pkg::*;
    logic main_supply_ok;
    logic power_on_request_n;
    logic reset_n;
    logic cmd_valid;
    cmd_e cmd_op;
    logic [7:0] cmd_arg;
    logic cmd_ok;
    logic interface_supply_on;
    logic rtc_backup_supply;
    logic ready;
    logic pins_driven;

    modport device (
        input main_supply_ok, power_on_request_n, reset_n, cmd_valid, cmd_op, cmd_arg,
        output cmd_ok, interface_supply_on, rtc_backup_supply, ready, pins_driven
    );
    modport host (
        output main_supply_ok, power_on_request_n, reset_n, cmd_valid, cmd_op, cmd_arg,
        input cmd_ok, interface_supply_on, rtc_backup_supply, ready, pins_driven
    );
endinterface : power_link_if

// >>> logic/power_seq_pkg.sv
// shared constants and types for the power-state sequencer link
package power_seq_pkg;
    localparam int unsigned CLK_HZ = 25_000_000;
    // minimum low durations, in microseconds
    localparam int unsigned POWER_ON_REQUEST_N_LOW_US = 50;
    localparam int unsigned RESET_LOW_US = 50;
    localparam int unsigned POWER_ON_REQUEST_N_LOW_CYC = (POWER_ON_REQUEST_N_LOW_US * (CLK_HZ / 1_000_000) > 0) ?
        POWER_ON_REQUEST_N_LOW_US * (CLK_HZ / 1_000_000) : 1;
    localparam int unsigned RESET_LOW_CYC = (RESET_LOW_US * (CLK_HZ / 1_000_000) > 0) ?
        RESET_LOW_US * (CLK_HZ / 1_000_000) : 1;
    // duration of the modelled save/detach routine and of pin configuration
    localparam int unsigned SAVE_CYC = 16;
    localparam int unsigned CONFIG_CYC = 8;
    localparam int unsigned CNT_W = 16;
    // functionality command argument that selects halt mode
    localparam logic [7:0] FUNC_HALT_ARG = 8'h7f;
    localparam logic [7:0] FUNC_RESET_ARG = 8'h10;

    typedef enum logic [1:0] {
        CMD_NONE,
        CMD_POWER_OFF,
        CMD_FUNCTIONALITY
    } cmd_e;

    typedef enum {
        ST_NOT_POWERED,
        ST_WAIT_RESET_RELEASE,
        ST_POWER_OFF,
        ST_INT_RESET,
        ST_CONFIG,
        ST_ACTIVE,
        ST_SAVING,
        ST_HALT
    } pstate_e;
endpackage : power_seq_pkg

// >>> logic/power_state_sequencer.sv
// device end: power-state sequencer of the cellular module
`timescale 1ns/1ps
module power_state_sequencer #(
    parameter bit CARD_VARIANT = 1'b0,
    parameter int unsigned POWER_ON_REQUEST_N_LOW = power_seq_pkg::POWER_ON_REQUEST_N_LOW_CYC,
    parameter int unsigned RESET_LOW = power_seq_pkg::RESET_LOW_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    power_link_if.device link,
    input wire logic rtc_alarm,
    output logic saving_settings,
    output logic network_detach,
    output logic core_reset
);
    import power_seq_pkg::*;

    // ============================================================
    // pin synchronisers
    logic [1:0] sup_s_q, pon_s_q, rst_s_q;
    logic sup_ok, pon_low, rst_low;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sup_s_q <= 2'h0;
            pon_s_q <= 2'h3;
            rst_s_q <= 2'h3;
        end else begin
            sup_s_q <= {sup_s_q[0], link.main_supply_ok};
            // an undriven input reads high through the pull-up
            pon_s_q <= {pon_s_q[0], link.power_on_request_n !== 1'b0};
            rst_s_q <= {rst_s_q[0], link.reset_n !== 1'b0};
        end
    end
    assign sup_ok = sup_s_q[1];
    assign pon_low = ~pon_s_q[1];
    assign rst_low = ~rst_s_q[1];

    // ============================================================
    // low-duration filters
    logic [CNT_W-1:0] pon_cnt_q, pon_cnt_d, rst_cnt_q, rst_cnt_d;
    logic pon_valid, rst_valid;
    always_comb begin
        pon_cnt_d = pon_low ? ((pon_cnt_q == CNT_W'(POWER_ON_REQUEST_N_LOW)) ? pon_cnt_q
                              : pon_cnt_q + CNT_W'(1)) : '0;
        rst_cnt_d = rst_low ? ((rst_cnt_q == CNT_W'(RESET_LOW)) ? rst_cnt_q
                              : rst_cnt_q + CNT_W'(1)) : '0;
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pon_cnt_q <= '0;
            rst_cnt_q <= '0;
        end else begin
            pon_cnt_q <= pon_cnt_d;
            rst_cnt_q <= rst_cnt_d;
        end
    end
    // one pulse as each filter first reaches its threshold
    assign pon_valid = (pon_cnt_d == CNT_W'(POWER_ON_REQUEST_N_LOW)) && (pon_cnt_q != CNT_W'(POWER_ON_REQUEST_N_LOW));
    assign rst_valid = (rst_cnt_d == CNT_W'(RESET_LOW)) && (rst_cnt_q != CNT_W'(RESET_LOW));

    // ============================================================
    // power-state machine
    pstate_e st_q, st_d;
    logic [CNT_W-1:0] tmr_q, tmr_d;
    logic reboot_q, reboot_d;
    logic ok_q, ok_d;
    logic vint_q, vint_d, bckp_q, bckp_d, rdy_q, rdy_d, pins_q, pins_d;
    logic sav_q, sav_d, det_q, det_d, crst_q, crst_d;
    logic cmd_take;
    assign cmd_take = link.cmd_valid && (st_q == ST_ACTIVE);

    always_comb begin
        st_d = st_q;
        tmr_d = tmr_q;
        reboot_d = reboot_q;
        ok_d = 1'b0;
        unique case (st_q)
            ST_NOT_POWERED: begin
                // request level is not looked at here
                if (sup_ok) begin
                    st_d = rst_low ? ST_WAIT_RESET_RELEASE : ST_INT_RESET;
                    tmr_d = CNT_W'(CONFIG_CYC);
                end
            end
            ST_WAIT_RESET_RELEASE: begin
                if (!rst_low) begin
                    st_d = ST_INT_RESET;
                    tmr_d = CNT_W'(CONFIG_CYC);
                end
            end
            ST_POWER_OFF: begin
                if (pon_valid || rst_valid || rtc_alarm) begin
                    st_d = ST_INT_RESET;
                    tmr_d = CNT_W'(CONFIG_CYC);
                end
            end
            ST_INT_RESET: begin
                // core held until the reset line is high again
                if (!rst_low) begin
                    st_d = ST_CONFIG;
                    tmr_d = CNT_W'(CONFIG_CYC);
                end
            end
            ST_CONFIG: begin
                if (tmr_q == '0) begin
                    st_d = ST_ACTIVE;
                end else begin
                    tmr_d = tmr_q - CNT_W'(1);
                end
            end
            ST_ACTIVE: begin
                if (rst_valid) begin
                    // abrupt: no save, no detach
                    st_d = CARD_VARIANT ? ST_INT_RESET : ST_POWER_OFF;
                end else if (cmd_take && link.cmd_op == CMD_POWER_OFF) begin
                    st_d = ST_SAVING;
                    reboot_d = CARD_VARIANT ? 1'b1 : 1'b0;
                    tmr_d = CNT_W'(SAVE_CYC);
                    ok_d = 1'b1;
                end else if (cmd_take && link.cmd_op == CMD_FUNCTIONALITY &&
                             (link.cmd_arg == FUNC_RESET_ARG ||
                              (CARD_VARIANT && link.cmd_arg == FUNC_HALT_ARG))) begin
                    st_d = ST_SAVING;
                    reboot_d = (link.cmd_arg == FUNC_RESET_ARG);
                    tmr_d = CNT_W'(SAVE_CYC);
                    ok_d = 1'b1;
                end else if (cmd_take) begin
                    ok_d = 1'b1;
                end
            end
            ST_SAVING: begin
                if (tmr_q == '0) begin
                    if (reboot_q) begin
                        st_d = ST_INT_RESET;
                    end else begin
                        st_d = CARD_VARIANT ? ST_HALT : ST_POWER_OFF;
                    end
                end else begin
                    tmr_d = tmr_q - CNT_W'(1);
                end
            end
            ST_HALT: begin
                st_d = ST_HALT;
            end
        endcase
        // supply loss overrides the next state from every state; cmd_ok is not masked
        if (!sup_ok) begin
            st_d = ST_NOT_POWERED;
        end
    end

    always_comb begin
        // outputs follow the next state, rtc_backup_supply follows sup_ok, so that they are registered
        vint_d = st_d inside {ST_INT_RESET, ST_CONFIG, ST_ACTIVE, ST_SAVING, ST_HALT};
        bckp_d = sup_ok;
        pins_d = st_d inside {ST_ACTIVE, ST_SAVING, ST_HALT} ||
                 (st_d == ST_CONFIG && vint_q);
        crst_d = st_d != ST_CONFIG && !(st_d inside {ST_ACTIVE, ST_SAVING, ST_HALT});
        rdy_d = st_d == ST_ACTIVE;
        sav_d = st_d == ST_SAVING;
        det_d = st_d == ST_SAVING && tmr_d < CNT_W'(SAVE_CYC / 2);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= ST_NOT_POWERED;
            tmr_q <= '0;
            reboot_q <= 1'b0;
            ok_q <= 1'b0;
            vint_q <= 1'b0;
            bckp_q <= 1'b0;
            pins_q <= 1'b0;
            crst_q <= 1'b1;
            rdy_q <= 1'b0;
            sav_q <= 1'b0;
            det_q <= 1'b0;
        end else begin
            st_q <= st_d;
            tmr_q <= tmr_d;
            reboot_q <= reboot_d;
            ok_q <= ok_d;
            vint_q <= vint_d;
            bckp_q <= bckp_d;
            pins_q <= pins_d;
            crst_q <= crst_d;
            rdy_q <= rdy_d;
            sav_q <= sav_d;
            det_q <= det_d;
        end
    end

    assign link.cmd_ok = ok_q;
    assign link.interface_supply_on = vint_q;
    assign link.rtc_backup_supply = bckp_q;
    assign link.ready = rdy_q;
    assign link.pins_driven = pins_q;
    assign saving_settings = sav_q;
    assign network_detach = det_q;
    assign core_reset = crst_q;
endmodule : power_state_sequencer

// >>> test/module_power_state_sequencer_tb.sv
// self-checking bench joining host end and sequencer end
`timescale 1ns/1ps
module module_power_state_sequencer_tb;
    import power_seq_pkg::*;
    // short low durations keep the run brief
    localparam int unsigned LOW = 4;
    logic clk;
    logic sys_rst;
    logic supply_enable;
    logic wake_request;
    logic hard_reset_request;
    logic cmd_request;
    cmd_e cmd_op_in;
    logic [7:0] cmd_arg_in;
    logic rtc_alarm;
    logic saving_settings;
    logic network_detach;
    logic core_reset;
    logic cmd_done;
    logic module_ready;
    logic module_on;
    logic saw_save;
    logic saw_det;
    logic saw_done;
    int fails;
    int checks_done;
    int cycles;
    power_link_if link ();
    wire [1:0] obs = {link.interface_supply_on, link.ready};
    power_state_sequencer #(.POWER_ON_REQUEST_N_LOW(LOW), .RESET_LOW(LOW)) u_power_state_sequencer (
        .clk(clk), .sys_rst(sys_rst), .link(link), .rtc_alarm(rtc_alarm),
        .saving_settings(saving_settings), .network_detach(network_detach),
        .core_reset(core_reset));
    power_host_ctrl #(.POWER_ON_REQUEST_N_LOW(LOW), .RESET_LOW(LOW)) u_power_host_ctrl (
        .clk(clk), .sys_rst(sys_rst), .link(link), .supply_enable(supply_enable),
        .wake_request(wake_request), .hard_reset_request(hard_reset_request),
        .cmd_request(cmd_request), .cmd_op_in(cmd_op_in), .cmd_arg_in(cmd_arg_in),
        .cmd_done(cmd_done), .module_ready(module_ready), .module_on(module_on));
    power_link_props u_power_link_props (
        .clk(clk), .sys_rst(sys_rst), .main_supply_ok(link.main_supply_ok),
        .power_on_request_n(link.power_on_request_n), .reset_n(link.reset_n),
        .cmd_valid(link.cmd_valid), .cmd_op(link.cmd_op), .cmd_arg(link.cmd_arg),
        .cmd_ok(link.cmd_ok), .interface_supply_on(link.interface_supply_on),
        .rtc_backup_supply(link.rtc_backup_supply), .ready(link.ready),
        .pins_driven(link.pins_driven));
    // ==========
    // clock, monitors, hang guard
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // sticky flags so one-cycle pulses are never missed
    always @(posedge clk) begin
        if (saving_settings === 1'b1) saw_save = 1'b1;
        if (network_detach === 1'b1) saw_det = 1'b1;
        if (cmd_done === 1'b1) saw_done = 1'b1;
        cycles++;
        if (cycles == 5000) begin
            fails++;
            summarize();
        end
    end
    // ==========
    // tasks
    task summarize();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize
    task step();
        @(posedge clk);
        #1;
    endtask : step
    task chk(input string nm, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %b seen %b", nm, e, g);
        end
    endtask : chk
    task clr();
        saw_save = 1'b0;
        saw_det = 1'b0;
        saw_done = 1'b0;
    endtask : clr
    task automatic wait_for(input int sel, input logic v);
        int n;
        n = 0;
        while (obs[sel] !== v && n < 300) begin
            step();
            n++;
        end
        chk("wait", v, obs[sel]);
    endtask : wait_for
    // model: supply on, ready and backup levels derived from the scenario
    task expect_state(input logic on, input logic rdy, input logic bk);
        repeat (3) step();
        chk("interface_supply_on", on, link.interface_supply_on);
        chk("ready", rdy, link.ready);
        chk("pins_driven", rdy, link.pins_driven);
        chk("rtc_backup_supply", bk, link.rtc_backup_supply);
        chk("module_on", on, module_on);
        chk("module_ready", rdy, module_ready);
    endtask : expect_state
    task automatic issue(input cmd_e op, input logic [7:0] arg);
        int n;
        n = 0;
        // the host drops a request made before it has seen ready
        while (module_ready !== 1'b1 && n < 300) begin
            step();
            n++;
        end
        clr();
        cmd_op_in = op;
        cmd_arg_in = arg;
        cmd_request = 1'b1;
        step();
        cmd_request = 1'b0;
        repeat (20) step();
        chk("cmd_done", 1'b1, saw_done);
    endtask : issue
    task pulse(input int sel);
        if (sel == 0) wake_request = 1'b1;
        else hard_reset_request = 1'b1;
        step();
        wake_request = 1'b0;
        hard_reset_request = 1'b0;
    endtask : pulse
    // ==========
    // main sequence
    initial begin
        sys_rst = 1'b1;
        supply_enable = 1'b0;
        wake_request = 1'b0;
        hard_reset_request = 1'b0;
        cmd_request = 1'b0;
        cmd_op_in = CMD_NONE;
        cmd_arg_in = 8'h00;
        rtc_alarm = 1'b0;
        fails = 0;
        checks_done = 0;
        cycles = 0;
        clr();
        void'($urandom(32'h8d70));
        repeat (12) @(posedge clk);
        chk("core_reset", 1'b1, core_reset);
        #1 sys_rst = 1'b0;
        expect_state(1'b0, 1'b0, 1'b0);
        supply_enable = 1'b1;
        wait_for(0, 1'b1);
        expect_state(1'b1, 1'b1, 1'b1);
        issue(CMD_FUNCTIONALITY, 8'($urandom_range(8'h7e, 8'h11)));
        expect_state(1'b1, 1'b1, 1'b1);
        issue(CMD_FUNCTIONALITY, FUNC_HALT_ARG);
        expect_state(1'b1, 1'b1, 1'b1);
        issue(CMD_FUNCTIONALITY, FUNC_RESET_ARG);
        wait_for(0, 1'b1);
        chk("saving_settings", 1'b1, saw_save);
        chk("network_detach", 1'b1, saw_det);
        issue(CMD_POWER_OFF, 8'h00);
        wait_for(1, 1'b0);
        chk("saving_settings", 1'b1, saw_save);
        chk("network_detach", 1'b1, saw_det);
        repeat (50) step();
        expect_state(1'b0, 1'b0, 1'b1);
        pulse(0);
        wait_for(0, 1'b1);
        clr();
        pulse(1);
        wait_for(1, 1'b0);
        expect_state(1'b0, 1'b0, 1'b1);
        chk("saving_settings", 1'b0, saw_save);
        pulse(1);
        wait_for(0, 1'b1);
        issue(CMD_POWER_OFF, 8'h00);
        wait_for(1, 1'b0);
        rtc_alarm = 1'b1;
        step();
        rtc_alarm = 1'b0;
        wait_for(0, 1'b1);
        clr();
        // host holds supply until the module has switched itself off
        supply_enable = 1'b0;
        repeat (6) step();
        chk("interface_supply_on", 1'b1, link.interface_supply_on);
        issue(CMD_POWER_OFF, 8'h00);
        wait_for(1, 1'b0);
        repeat (6) step();
        expect_state(1'b0, 1'b0, 1'b0);
        chk("main_supply_ok", 1'b0, link.main_supply_ok);
        supply_enable = 1'b1;
        pulse(1);
        pulse(0);
        repeat (4) step();
        chk("interface_supply_on", 1'b0, link.interface_supply_on);
        wait_for(0, 1'b1);
        expect_state(1'b1, 1'b1, 1'b1);
        summarize();
    end
endmodule : module_power_state_sequencer_tb

// >>> test/power_link_props.sv
// assertion checker watching the power link between host and sequencer
`timescale 1ns/1ps
module power_link_props (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic main_supply_ok,
    input wire logic power_on_request_n,
    input wire logic reset_n,
    input wire logic cmd_valid,
    input wire power_seq_pkg::cmd_e cmd_op,
    input wire logic [7:0] cmd_arg,
    input wire logic cmd_ok,
    input wire logic interface_supply_on,
    input wire logic rtc_backup_supply,
    input wire logic ready,
    input wire logic pins_driven
);
    import power_seq_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ==========
    // assertions
    AST_PINS_AFTER_SUPPLY: assert property (pins_driven |-> interface_supply_on)
        else $error("pins driven without interface supply");
    AST_READY_PINS: assert property (ready |-> pins_driven && interface_supply_on)
        else $error("ready while pins or supply off");
    // power-on request level is left free here on purpose
    AST_SWITCH_ON: assert property (
        $rose(main_supply_ok) && reset_n |-> ##[1:8] interface_supply_on)
        else $error("no switch-on after supply rise");
    AST_BACKUP_ON: assert property (main_supply_ok [*4] |-> rtc_backup_supply)
        else $error("backup supply off with supply present");
    AST_DOWN_ON_LOSS: assert property (
        !main_supply_ok [*4] |-> !rtc_backup_supply && !interface_supply_on && !ready)
        else $error("outputs alive after supply loss");
    AST_OK_ONE: assert property (cmd_ok |=> !cmd_ok)
        else $error("command reply wider than one cycle");
    AST_OK_ANSWER: assert property (cmd_valid && ready |-> ##[1:4] cmd_ok)
        else $error("accepted command not answered");
    AST_OFF_ROUTINE: assert property (cmd_valid && ready && cmd_op == CMD_POWER_OFF
        |-> ##[1:4] !ready ##[1:40] !interface_supply_on)
        else $error("power-off routine did not end");
    AST_ABRUPT: assert property (!reset_n [*8] |-> ##[0:4] !ready)
        else $error("long reset low left device ready");
    // request pulses from the host last eight cycles
    AST_WAKE_REQUEST: assert property (
        !power_on_request_n [*8] ##0 main_supply_ok |-> ##[0:8] interface_supply_on)
        else $error("long wake request low did not switch on");
    // ==========
    // coverage
    cover property (cmd_ok);
    cover property ($fell(interface_supply_on) && main_supply_ok);
    cover property ($rose(ready));
endmodule : power_link_props
